// ==== verilog/rhw_pkg.sv ====
// Operation
// (RQ1) Idle to wake-up: enable, no burst, idle time
// (RQ2) Wake-up ends when wake-up timer runs out
// (RQ3) Low-side on ends: min time, low threshold/max
// (RQ4) Dead time ends: startup, max, slew, polarity
// (RQ5) Config bit adds matched dead time on rise
// (RQ6) High-side on ends: min time, high threshold/max
// (RQ7) Low-side exit to idle on fault counter expiry
// (RQ8) High-side to idle for burst-off
// (RQ9) Startup counter loads 15 on enable rise
// (RQ10) Startup timeout ignored once startup counter zero
// (RQ11) Startup dead-time clamp only before counter expiry
// (RQ12) Burst counter 15 down; halt while feedback low
// (RQ13) Overcurrent counter loads 4, counts faulty cycles
// (RQ14) Overvoltage counter decrements per event; the code steps once per cycle that bias_overvoltage is high
// (RQ15) Count every completed switching cycle
// (RQ16) Enable low returns any active state to idle
// (RQ17) State timers restart on entry, fixed limits
// (RQ18) Idle entry reloads counters; outputs low; the code reloads the startup counter only on enable rise, not on idle entry
// (RQ19) Fixed state order of the cycle
// (RQ20) Gates and ramps decoded from state
// (RQ21) Polarity blanked 1us during dead time
`default_nettype none
package rhw_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_WAKE, ST_LOW_SIDE_ON_STATE, ST_DT_RISE, ST_HIGH_SIDE_ON_STATE, ST_DT_FALL
	} rhw_state_e;

	// *****************************************
	// Timing
	// *****************************************
	localparam int          CLK_NS       = 10;
	localparam int          TMR_W        = 12;
	localparam int          IDLE_MIN_NS  = 1000;
	localparam int          WAKE_NS      = 2000;
	localparam int          ON_MIN_NS    = 500;
	localparam int          ON_MAX_NS    = 20000;
	localparam int          DT_MAX_NS    = 1500;
	localparam int          SU_DT_NS     = 600;
	localparam int          BLANK_NS     = 1000;
	localparam logic [11:0] IDLE_MIN_CYC = 12'((IDLE_MIN_NS+CLK_NS-1)/CLK_NS);
	localparam logic [11:0] WAKE_CYC     = 12'((WAKE_NS+CLK_NS-1)/CLK_NS);
	localparam logic [11:0] ON_MIN_CYC   = 12'((ON_MIN_NS+CLK_NS-1)/CLK_NS);
	localparam logic [11:0] ON_MAX_CYC   = 12'(ON_MAX_NS / CLK_NS);
	localparam logic [11:0] DT_MAX_CYC   = 12'(DT_MAX_NS / CLK_NS);
	localparam logic [11:0] SU_DT_CYC    = 12'(SU_DT_NS / CLK_NS);
	localparam logic [11:0] BLANK_CYC    = 12'((BLANK_NS+CLK_NS-1)/CLK_NS);

	// *****************************************
	// Counter loads
	// *****************************************
	localparam logic [3:0]  STARTUP_LOAD = 4'hf;
	localparam logic [3:0]  BURST_LOAD   = 4'hf;
	localparam logic [2:0]  OCP_LOAD     = 3'h4;
	localparam logic [2:0]  OVP_LOAD_DEF = 3'h4;

	// *****************************************
	// Register map
	// *****************************************
	localparam int          AXI_AW       = 4;
	localparam logic [3:0]  REG_CTRL     = 4'h0;
	localparam logic [3:0]  REG_STATUS   = 4'h4;
	localparam logic [3:0]  REG_CYCLES   = 4'h8;
	localparam int          CTRL_MATCH   = 0;
	localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_DECERR  = 2'h3;
endpackage
`default_nettype wire

// ==== verilog/rhw_timer.sv ====
`default_nettype none
// Saturating up-counter of cycles spent in the current state
module rhw_timer #(
	parameter int W = 12
) (
	input  wire logic         mclk,
	input  wire logic         srst,
	input  wire logic         restart,
	output logic      [W-1:0] count
);
	// Restart on state entry, hold at full scale
	always_ff @(posedge mclk) begin
		if (srst || restart) begin
			count <= '0;
		end else if (count != '1) begin
			count <= count + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/rhw_axi_regs.sv ====
`default_nettype none
// AXI4-Lite slave: control register and read-back of block state
module rhw_axi_regs (
	input  wire logic                      mclk,
	input  wire logic                      srst,
	input  wire logic [rhw_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic      [1:0]                s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [rhw_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic      [31:0]               s_axi_rdata,
	output logic      [1:0]                s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic [31:0]               status_word,
	input  wire logic [31:0]               cycles_word,
	output logic      [31:0]               ctrl
);
	import rhw_pkg::*;
	logic [AXI_AW-1:0] aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              do_write;

	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	// Write channels taken in either order, answer after both
	always_ff @(posedge mclk) begin
		if (srst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_addr       <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr == REG_CTRL || aw_addr == REG_STATUS
					|| aw_addr == REG_CYCLES) ? RESP_OKAY : RESP_DECERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Control register, only bit 0 (CTRL_MATCH) holds a bit
	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl <= CTRL_RST;
		end else if (do_write && aw_addr == REG_CTRL && w_strb[0]) begin
			ctrl <= {31'h0000_0000, w_data[CTRL_MATCH]};
		end
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge mclk) begin
		if (srst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			unique case (s_axi_araddr)
				REG_CTRL:   s_axi_rdata <= ctrl;
				REG_STATUS: s_axi_rdata <= status_word;
				REG_CYCLES: s_axi_rdata <= cycles_word;
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_DECERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// *****************************************
	// Checks
	// *****************************************
	bresp_after_both_a: assert property (@(posedge mclk) disable iff (srst)
		$rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
		else $error("write answer before both channels taken");
endmodule
`default_nettype wire

// ==== verilog/rhw_wavegen.sv ====
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
// Half-bridge resonant waveform sequencer
module rhw_wavegen #(
	parameter logic [2:0] OVP_LOAD = rhw_pkg::OVP_LOAD_DEF
) (
	input  wire logic                      mclk,
	input  wire logic                      srst,
	input  wire logic                      waveform_enable,
	input  wire logic                      fb_below_burst_threshold,
	input  wire logic                      cap_voltage_below_low_thresh,
	input  wire logic                      cap_voltage_above_high_thresh,
	input  wire logic                      cap_voltage_above_midpoint,
	input  wire logic                      rise_slew_complete,
	input  wire logic                      fall_slew_complete,
	input  wire logic                      current_polarity,
	input  wire logic                      matched_deadtime_done,
	input  wire logic                      overcurrent_level1,
	input  wire logic                      bias_overvoltage,
	output logic                           gate_high,
	output logic                           gate_low,
	output logic                           high_ramp_active,
	output logic                           low_ramp_active,
	input  wire logic [rhw_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic      [1:0]                s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [rhw_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic      [31:0]               s_axi_rdata,
	output logic      [1:0]                s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready
);
	import rhw_pkg::*;

	rhw_state_e        state;
	rhw_state_e        next_state;
	logic [TMR_W-1:0]  tmr;
	logic [31:0]       ctrl;
	logic [3:0]        startup_cnt;
	logic [3:0]        burst_cnt;
	logic [2:0]        ocp_cnt;
	logic [2:0]        ovp_cnt;
	logic [15:0]       cycle_cnt;
	logic              en_q;
	logic              pol_q;
	logic              ocp_seen;
	logic              en_rise;
	logic              in_dt;
	logic              current_polarity_fall;
	logic              startup_count_done;
	logic              startup_deadtime_timeout;
	logic              deadtime_max_timeout;
	logic              burst_count_done;
	logic              ls_exit;
	logic              hs_exit;
	logic              dt_common;
	logic              rise_end;
	logic              burst_off;
	logic              fault_stop;
	logic              cycle_end;
	logic              idle_entry;

	// *****************************************
	// Register bus
	// *****************************************
	rhw_axi_regs u_regs (
		.mclk          (mclk),
		.srst          (srst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.status_word   ({12'h000, 1'b0, ovp_cnt, 1'b0, ocp_cnt,
			burst_cnt, startup_cnt, 1'b0, state}),
		.cycles_word   ({16'h0000, cycle_cnt}),
		.ctrl          (ctrl)
	);

	// *****************************************
	// State timer
	// *****************************************
	// Restarts whenever the state changes
	rhw_timer #(.W(TMR_W)) u_tmr (
		.mclk    (mclk),
		.srst    (srst),
		.restart (next_state != state), // [RQ17]
		.count   (tmr)
	);

	// *****************************************
	// Transition terms
	// *****************************************
	assign en_rise    = waveform_enable && !en_q;
	assign in_dt      = state == ST_DT_RISE || state == ST_DT_FALL;
	assign current_polarity_fall = in_dt && tmr >= BLANK_CYC
		&& pol_q && !current_polarity; // [RQ21]
	assign startup_count_done       = startup_cnt == 4'h0;
	assign startup_deadtime_timeout = tmr >= SU_DT_CYC;
	assign deadtime_max_timeout     = tmr >= DT_MAX_CYC;
	assign burst_count_done         = burst_cnt == 4'h0;
	assign ls_exit = tmr >= ON_MIN_CYC
		&& (cap_voltage_below_low_thresh || tmr >= ON_MAX_CYC); // [RQ3]
	assign hs_exit = tmr >= ON_MIN_CYC
		&& (cap_voltage_above_high_thresh || tmr >= ON_MAX_CYC); // [RQ6]
	// Startup clamp only counts before the startup counter expires
	assign dt_common = (!startup_count_done && startup_deadtime_timeout)
		|| deadtime_max_timeout || current_polarity_fall; // [RQ4] [RQ10] [RQ11]
	assign rise_end = ctrl[CTRL_MATCH]
		? rise_slew_complete && matched_deadtime_done
		: rise_slew_complete; // [RQ5]
	assign burst_off = burst_count_done && cap_voltage_above_midpoint
		&& fb_below_burst_threshold && tmr >= ON_MIN_CYC; // [RQ8] [RQ12]
	assign fault_stop = ocp_cnt == 3'h0 || ovp_cnt == 3'h0; // [RQ7]
	assign cycle_end  = state == ST_DT_FALL && next_state == ST_LOW_SIDE_ON_STATE;
	assign idle_entry = next_state == ST_IDLE && state != ST_IDLE;

	// Next-state selection
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (waveform_enable && !fb_below_burst_threshold
					&& tmr >= IDLE_MIN_CYC) begin
					next_state = ST_WAKE; // [RQ1]
				end
			end
			ST_WAKE: begin
				if (!waveform_enable) begin
					next_state = ST_IDLE; // [RQ16]
				end else if (tmr >= WAKE_CYC) begin
					next_state = ST_LOW_SIDE_ON_STATE; // [RQ2] [RQ19]
				end
			end
			ST_LOW_SIDE_ON_STATE: begin
				if (!waveform_enable) begin
					next_state = ST_IDLE; // [RQ16]
				end else if (ls_exit) begin
					next_state = fault_stop ? ST_IDLE : ST_DT_RISE; // [RQ7]
				end
			end
			ST_DT_RISE: begin
				if (!waveform_enable) begin
					next_state = ST_IDLE; // [RQ16]
				end else if (dt_common || rise_end) begin
					next_state = ST_HIGH_SIDE_ON_STATE; // [RQ4] [RQ19]
				end
			end
			ST_HIGH_SIDE_ON_STATE: begin
				if (!waveform_enable || burst_off) begin
					next_state = ST_IDLE; // [RQ16] [RQ8]
				end else if (hs_exit) begin
					next_state = ST_DT_FALL; // [RQ19]
				end
			end
			ST_DT_FALL: begin
				if (!waveform_enable) begin
					next_state = ST_IDLE; // [RQ16]
				end else if (dt_common || fall_slew_complete) begin
					next_state = ST_LOW_SIDE_ON_STATE; // [RQ4] [RQ19]
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Gate and ramp commands, registered from the next state
	always_ff @(posedge mclk) begin
		if (srst) begin
			gate_low         <= 1'b0;
			gate_high        <= 1'b0;
			low_ramp_active  <= 1'b0;
			high_ramp_active <= 1'b0;
		end else begin
			gate_low         <= next_state == ST_LOW_SIDE_ON_STATE; // [RQ20] [RQ18]
			gate_high        <= next_state == ST_HIGH_SIDE_ON_STATE; // [RQ20]
			low_ramp_active  <= next_state == ST_LOW_SIDE_ON_STATE
				|| next_state == ST_DT_FALL; // [RQ20]
			high_ramp_active <= next_state == ST_HIGH_SIDE_ON_STATE
				|| next_state == ST_DT_RISE; // [RQ20]
		end
	end

	// Input history for edge detection
	always_ff @(posedge mclk) begin
		if (srst) begin
			en_q  <= 1'b0;
			pol_q <= 1'b0;
		end else begin
			en_q  <= waveform_enable;
			pol_q <= current_polarity;
		end
	end

	// *****************************************
	// Cycle counters
	// *****************************************
	// Startup counter: load on enable rise, one step per completed switching cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			startup_cnt <= 4'h0;
		end else if (en_rise) begin
			startup_cnt <= STARTUP_LOAD; // [RQ9] [RQ18]
		end else if (cycle_end && !startup_count_done) begin
			startup_cnt <= startup_cnt - 4'h1; // [RQ9]
		end
	end

	// Burst counter: reload in idle, count down to zero
	always_ff @(posedge mclk) begin
		if (srst || idle_entry) begin
			burst_cnt <= BURST_LOAD; // [RQ18]
		end else if (cycle_end && !burst_count_done) begin
			burst_cnt <= burst_cnt - 4'h1; // [RQ12]
		end
	end

	// Overcurrent seen within the current cycle; a new event wins
	always_ff @(posedge mclk) begin
		if (srst) begin
			ocp_seen <= 1'b0;
		end else begin
			ocp_seen <= state != ST_IDLE
				&& (overcurrent_level1 || (ocp_seen && !cycle_end));
		end
	end

	// Overcurrent counter: one step per faulty cycle
	always_ff @(posedge mclk) begin
		if (srst || idle_entry) begin
			ocp_cnt <= OCP_LOAD; // [RQ18]
		end else if (cycle_end && (ocp_seen || overcurrent_level1)
			&& ocp_cnt != 3'h0) begin
			ocp_cnt <= ocp_cnt - 3'h1; // [RQ13]
		end
	end

	// Overvoltage counter: one step per cycle that bias_overvoltage is high
	always_ff @(posedge mclk) begin
		if (srst || idle_entry) begin
			ovp_cnt <= OVP_LOAD; // [RQ18]
		end else if (bias_overvoltage && ovp_cnt != 3'h0) begin
			ovp_cnt <= ovp_cnt - 3'h1; // [RQ14]
		end
	end

	// Completed switching cycles since idle
	always_ff @(posedge mclk) begin
		if (srst || idle_entry) begin
			cycle_cnt <= 16'h0000; // [RQ18]
		end else if (cycle_end) begin
			cycle_cnt <= cycle_cnt + 16'h0001; // [RQ15]
		end
	end

	// *****************************************
	// Checks
	// *****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	idle_exit_a: assert property ( // [RQ1]
		state == ST_IDLE && next_state == ST_WAKE
		|-> waveform_enable && !fb_below_burst_threshold
		&& tmr >= IDLE_MIN_CYC)
		else $error("left idle without its conditions");
	wake_exit_a: assert property ( // [RQ2]
		state == ST_WAKE && waveform_enable && tmr == WAKE_CYC
		|=> state == ST_LOW_SIDE_ON_STATE)
		else $error("wake-up did not end on its timer");
	low_on_exit_a: assert property ( // [RQ3]
		$past(state) == ST_LOW_SIDE_ON_STATE && state == ST_DT_RISE
		|-> $past(tmr) >= ON_MIN_CYC)
		else $error("low-side on ended before minimum time");
	high_on_exit_a: assert property ( // [RQ6]
		state == ST_HIGH_SIDE_ON_STATE && waveform_enable && tmr < ON_MIN_CYC
		|=> state == ST_HIGH_SIDE_ON_STATE)
		else $error("high-side on ended before minimum time");
	dt_max_end_a: assert property ( // [RQ4]
		in_dt && waveform_enable && deadtime_max_timeout
		|=> !in_dt || state != $past(state))
		else $error("dead time outlived its maximum");
	enable_drop_a: assert property ( // [RQ16]
		state != ST_IDLE && !waveform_enable |=> state == ST_IDLE)
		else $error("enable low did not stop the sequence");
	startup_load_a: assert property ( // [RQ9]
		en_rise |=> startup_cnt == 4'hf)
		else $error("startup counter not loaded on enable rise");
	ocp_step_a: assert property ( // [RQ13]
		cycle_end && ocp_seen && ocp_cnt != 3'h0 && !idle_entry
		|=> ocp_cnt == $past(ocp_cnt) - 3'h1)
		else $error("overcurrent counter missed a step");
	gate_decode_a: assert property ( // [RQ20]
		gate_low == (state == ST_LOW_SIDE_ON_STATE) && gate_high == (state == ST_HIGH_SIDE_ON_STATE)
		&& high_ramp_active == (state == ST_HIGH_SIDE_ON_STATE || state == ST_DT_RISE))
		else $error("outputs disagree with state");
	gates_idle_a: assert property ( // [RQ18]
		state == ST_IDLE |-> !gate_low && !gate_high
		&& !low_ramp_active && !high_ramp_active)
		else $error("output active in idle");
	order_rise_a: assert property ( // [RQ19]
		$past(state) == ST_DT_RISE && state != ST_DT_RISE
		|-> state == ST_HIGH_SIDE_ON_STATE || state == ST_IDLE)
		else $error("rising dead time left to wrong state");
	blank_pol_a: assert property ( // [RQ21]
		in_dt && tmr < BLANK_CYC && waveform_enable && !rise_slew_complete
		&& !fall_slew_complete && !deadtime_max_timeout
		&& !(startup_deadtime_timeout && !startup_count_done)
		|=> state == $past(state))
		else $error("dead time ended inside blanking");

	full_cycle_c: cover property (cycle_end);
	burst_off_c:  cover property (state == ST_HIGH_SIDE_ON_STATE && burst_off);
	fault_off_c:  cover property (state == ST_LOW_SIDE_ON_STATE && ls_exit && fault_stop);
	matched_c:    cover property (state == ST_DT_RISE && ctrl[CTRL_MATCH]
		&& rise_end);
endmodule
`default_nettype wire

// ==== test/rhw_far_model.sv ====
`default_nettype none
// Behavioural bridge and comparators: reacts to gate and ramp commands
module rhw_far_model (
	input  wire logic mclk,
	input  wire logic slow,
	input  wire logic gate_high,
	input  wire logic gate_low,
	input  wire logic high_ramp_active,
	input  wire logic low_ramp_active,
	output logic      rise_slew_complete,
	output logic      fall_slew_complete,
	output logic      cap_voltage_below_low_thresh,
	output logic      cap_voltage_above_high_thresh,
	output logic      cap_voltage_above_midpoint
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] code;
	logic [3:0] last = 4'h0;
	logic [7:0] age  = 8'h00;
	assign code = {gate_high, gate_low, high_ramp_active, low_ramp_active};
	// ********
	// Cycles spent in the present bridge state, saturating
	// ********
	always_ff @(posedge mclk) begin
		last <= code;
		if (code != last) age <= 8'h00;
		else if (age != 8'hff) age <= age + 8'h01;
	end
	// Slew never completes in slow mode, so the dead time hits a clamp
	assign rise_slew_complete = code == 4'h2 && last == code
		&& !slow && age > 8'h04;
	assign fall_slew_complete = code == 4'h1 && last == code
		&& !slow && age > 8'h04;
	// Tank thresholds trip early, so the minimum on time decides
	assign cap_voltage_below_low_thresh  = code == 4'h5 && age > 8'h09;
	assign cap_voltage_above_high_thresh = code == 4'ha && age > 8'h09;
	assign cap_voltage_above_midpoint    = code == 4'ha;
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import rhw_pkg::*;
	localparam logic [31:0] ONE = 32'h0000_0001;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic        waveform_enable = 1'b0;
	logic        fb_below_burst_threshold = 1'b0;
	logic        matched_deadtime_done = 1'b0;
	logic        overcurrent_level1 = 1'b0;
	logic        bias_overvoltage = 1'b0;
	logic        current_polarity = 1'b1;
	logic        slow = 1'b1;
	logic [3:0]  s_axi_awaddr = 4'h0;
	logic [3:0]  s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	wire         gate_high, gate_low, high_ramp_active, low_ramp_active;
	wire         rise_slew_complete, fall_slew_complete;
	wire         cap_voltage_below_low_thresh, cap_voltage_above_high_thresh;
	wire         cap_voltage_above_midpoint, s_axi_awready, s_axi_wready;
	wire         s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	int          n_errors = 0;
	int          num_checks = 0;
	int          wd = 0;
	int          rel = 0;

	rhw_wavegen #(.OVP_LOAD(3'h5)) dut (
		.mclk, .srst, .waveform_enable, .fb_below_burst_threshold,
		.cap_voltage_below_low_thresh, .cap_voltage_above_high_thresh,
		.cap_voltage_above_midpoint, .rise_slew_complete,
		.fall_slew_complete, .current_polarity, .matched_deadtime_done,
		.overcurrent_level1, .bias_overvoltage, .gate_high, .gate_low,
		.high_ramp_active, .low_ramp_active, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);
	rhw_far_model far (
		.mclk, .slow, .gate_high, .gate_low, .high_ramp_active,
		.low_ramp_active, .rise_slew_complete, .fall_slew_complete,
		.cap_voltage_below_low_thresh, .cap_voltage_above_high_thresh,
		.cap_voltage_above_midpoint
	);

	// Clock and hang guard
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk) begin
		wd <= wd + 1;
		if (wd == 20000) begin
			n_errors++;
			close_out();
		end
	end

	// ********
	// Shared helpers
	// ********
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] near(input int n, input int e);
		return 32'(n >= e - 1 && n <= e + 2);
	endfunction
	function automatic logic [3:0] code();
		return {gate_high, gate_low, high_ramp_active, low_ramp_active};
	endfunction
	task automatic axw(input logic [3:0] a, input logic [31:0] d,
			output logic [1:0] r);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [3:0] a, output logic [31:0] d,
			output logic [1:0] r);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rdk(input logic [3:0] a, input logic [31:0] m,
			input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axr(a, d, r);
		chk(d & m, e);
	endtask
	task automatic seek(input logic [3:0] c);
		int n = 0;
		while (code() !== c && n < 9000) begin
			@(posedge mclk);
			n++;
		end
	endtask
	task automatic dur(input logic [3:0] c, output int n);
		seek(c);
		n = 0;
		while (code() === c) begin
			@(posedge mclk);
			n++;
		end
	endtask
	// Counts completed cycles until idle; p is the state left for idle
	task automatic to_idle(output int k, output logic [3:0] p);
		logic [3:0] q;
		k = 0;
		q = code();
		repeat (5000) begin
			@(posedge mclk);
			if (q === 4'h1 && code() === 4'h5) k++;
			if (code() === 4'h0) break;
			q = code();
		end
		p = q;
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		chk(32'(code()), 32'h0000_0000);
		rdk(REG_STATUS, 32'hffff_ffff, 32'h0005_4f00);
		rdk(REG_CYCLES, 32'hffff_ffff, 32'h0000_0000);
		axr(4'hc, d, r);
		chk({d[31:2], r}, {30'h0, RESP_DECERR});
		axw(4'hc, 32'h0000_0001, r);
		chk(32'(r), 32'(RESP_DECERR));
		rdk(REG_CTRL, 32'hffff_ffff, CTRL_RST);
	endtask
	task automatic t_start();
		int n;
		int t;
		waveform_enable <= 1'b1;
		fb_below_burst_threshold <= 1'b1;
		while (wd - rel < 150) @(posedge mclk);
		fb_below_burst_threshold <= 1'b0;
		t = wd;
		seek(4'h5);
		chk(near(wd - t, 201), ONE);
		dur(4'h5, n);
		chk(near(n, 50), ONE);
		chk(32'(code()), 32'h0000_0002);
		dur(4'h2, n);
		chk(near(n, 60), ONE);
		chk(32'(code()), 32'h0000_000a);
		dur(4'ha, n);
		chk(near(n, 50), ONE);
		chk(32'(code()), 32'h0000_0001);
		dur(4'h1, n);
		chk(near(n, 60), ONE);
		rdk(REG_STATUS, 32'h0000_00f7, 32'h0000_00e2);
		repeat (15) begin
			seek(4'h1);
			seek(4'h5);
		end
		rdk(REG_STATUS, 32'h0000_00f0, 32'h0000_0000);
		rdk(REG_CYCLES, 32'h0000_ffff, 32'h0000_0010);
		dur(4'h2, n);
		chk(near(n, 150), ONE);
		seek(4'h1);
		repeat (120) @(posedge mclk);
		current_polarity <= 1'b0;
		dur(4'h1, n);
		chk(32'(n < 5), ONE);
		current_polarity <= 1'b1;
	endtask
	task automatic t_match();
		int n;
		logic [1:0] r;
		slow <= 1'b0;
		axw(REG_CTRL, 32'h0000_0001, r);
		dur(4'h2, n);
		chk(near(n, 150), ONE);
		dur(4'h1, n);
		chk(32'(n < 10), ONE);
		matched_deadtime_done <= 1'b1;
		dur(4'h2, n);
		chk(32'(n < 10), ONE);
		axw(REG_CTRL, 32'h0000_0000, r);
		matched_deadtime_done <= 1'b0;
	endtask
	task automatic t_fault();
		int k;
		logic [3:0] p;
		bias_overvoltage <= 1'b1;
		repeat (2) @(posedge mclk);
		bias_overvoltage <= 1'b0;
		rdk(REG_STATUS, 32'h0007_0000, 32'h0003_0000);
		seek(4'h5);
		overcurrent_level1 <= 1'b1;
		to_idle(k, p);
		overcurrent_level1 <= 1'b0;
		chk(32'(p), 32'h0000_0005);
		chk(32'(k >= 4 && k <= 5), ONE);
		rdk(REG_STATUS, 32'h0007_7f07, 32'h0005_4f00);
	endtask
	task automatic t_burst();
		int k;
		int t;
		logic [3:0] p;
		seek(4'h5);
		fb_below_burst_threshold <= 1'b1;
		to_idle(k, p);
		chk(32'(p), 32'h0000_000a);
		chk(32'(k >= 14 && k <= 16), ONE);
		repeat (300) @(posedge mclk);
		chk(32'(code()), 32'h0000_0000);
		fb_below_burst_threshold <= 1'b0;
		t = wd;
		seek(4'h5);
		chk(near(wd - t, 201), ONE);
	endtask
	task automatic t_off();
		seek(4'ha);
		waveform_enable <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(32'(code()), 32'h0000_0000);
		waveform_enable <= 1'b1;
		rdk(REG_STATUS, 32'h0000_00f7, 32'h0000_00f0);
	endtask

	// Main sequence
	initial begin
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		rel = wd;
		t_reset();
		t_start();
		t_match();
		t_fault();
		t_burst();
		t_off();
		close_out();
	end
endmodule
`default_nettype wire
